// ==== rtl/ccs_top.v ====
// Calibration coefficient store: system registers, programming control, outputs.
//
// The placing of the registers and the Avalon-MM slave port were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "ccs_map.vh"
module ccs_top (
  // Clock and resets
  input wire mclk,
  input wire rst_b,
  input wire nvm_clear_b,
  // Avalon-MM slave
  input wire [7:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  // Sensor data
  input wire [15:0] raw_temp,
  input wire [23:0] raw_rate,
  input wire [23:0] comp_rate,
  // Outputs
  output wire [15:0] temp_out,
  output reg [23:0] rate_out,
  output reg data_ready,
  // Active rate compensation coefficients
  output reg [15:0] scale_coef_quadratic,
  output reg [15:0] bias_coef_quadratic,
  output reg [29:0] bias_coef_linear,
  output reg [29:0] bias_coef_constant,
  output reg [29:0] scale_coef_linear,
  output reg [29:0] scale_coef_constant,
  output reg [19:0] mid_temperature_point
);
  localparam ST_LOAD = 4'b0001;
  localparam ST_IDLE = 4'b0010;
  localparam ST_PROG = 4'b0100;
  localparam ST_COPY = 4'b1000;

  reg [31:0] sys_r [0:8];
  reg [3:0] state_r;
  reg [3:0] state_nxt;
  reg [3:0] idx_r;
  reg [3:0] prog_idx_r;
  reg [7:0] nvm_slot_r;
  reg err_r;
  reg err_set;
  reg wr_prog;
  reg wr_eff;
  reg pend_set;
  reg pend_clr;
  reg [31:0] rd_mux;
  integer b;

  wire [3:0] bus_idx;
  wire [3:0] cmd_idx;
  wire [31:0] rd_prog_data;
  wire [31:0] rd_eff_data;
  wire pend;
  wire req;
  wire acc;
  wire acc_wr;
  wire cmd_go;
  wire slot_full;
  wire [7:0] slot_new;
  wire slot_ok;
  wire [3:0] wr_idx;
  wire [31:0] wr_data;

  // ----------------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------------
  function [3:0] word_to_idx;
    input [7:0] a;
    begin
      case (a)
        `CCS_W_SLOT: word_to_idx = `CCS_I_SLOT;
        `CCS_W_TCAL: word_to_idx = `CCS_I_TCAL;
        `CCS_W_TSEL: word_to_idx = `CCS_I_TSEL;
        `CCS_W_SF2B2: word_to_idx = `CCS_I_SF2B2;
        `CCS_W_B1: word_to_idx = `CCS_I_B1;
        `CCS_W_B0: word_to_idx = `CCS_I_B0;
        `CCS_W_SF1: word_to_idx = `CCS_I_SF1;
        `CCS_W_SF0: word_to_idx = `CCS_I_SF0;
        `CCS_W_MID_TEMPERATURE_POINT: word_to_idx = `CCS_I_MID_TEMPERATURE_POINT;
        default: word_to_idx = `CCS_I_BAD;
      endcase
    end
  endfunction

  assign bus_idx = word_to_idx(avs_address);
  assign cmd_idx = word_to_idx(avs_writedata[`CCS_CMD_HI:0]);
  assign req = avs_read | avs_write;
  // A request completes at the edge where waitrequest is seen low.
  assign acc = req & ~avs_waitrequest;
  assign acc_wr = acc & avs_write;
  assign cmd_go = acc_wr & (avs_address == `CCS_W_CMD);

  // ----------------------------------------------------------------------
  // Slot accounting
  // ----------------------------------------------------------------------
  assign slot_full = (nvm_slot_r == `CCS_SLOT_FULL);
  assign slot_new = sys_r[`CCS_I_SLOT][`CCS_SLOT_HI:`CCS_SLOT_LO];
  // Only a single thermometer step is accepted as a slot advance.
  assign slot_ok = (slot_new == {nvm_slot_r[6:0], 1'b1});

  // ----------------------------------------------------------------------
  // Nonvolatile store
  // ----------------------------------------------------------------------
  assign wr_idx = state_r[3] ? idx_r : prog_idx_r;
  assign wr_data = state_r[3] ? rd_prog_data : sys_r[prog_idx_r];

  ccs_nvm u_nvm (
    .mclk(mclk),
    .nvm_clear_b(nvm_clear_b),
    .wr_prog(wr_prog),
    .wr_eff(wr_eff),
    .wr_idx(wr_idx),
    .wr_data(wr_data),
    .pend_set(pend_set),
    .pend_clr(pend_clr),
    .rd_idx(idx_r),
    .rd_prog_data(rd_prog_data),
    .rd_eff_data(rd_eff_data),
    .pend_r(pend)
  );

  // ----------------------------------------------------------------------
  // Control sequence
  // ----------------------------------------------------------------------
  always @* begin
    state_nxt = state_r;
    wr_prog = 1'b0;
    wr_eff = 1'b0;
    pend_set = 1'b0;
    pend_clr = 1'b0;
    err_set = 1'b0;
    case (state_r)
      ST_LOAD: begin
        if (idx_r == `CCS_I_LAST)
          state_nxt = ST_IDLE;
      end
      ST_IDLE: begin
        if (cmd_go) begin
          // Refuse unknown words and anything once all slots are used.
          if (cmd_idx == `CCS_I_BAD || slot_full)
            err_set = 1'b1;
          else
            state_nxt = ST_PROG;
        end
      end
      ST_PROG: begin
        state_nxt = ST_IDLE;
        if (prog_idx_r == `CCS_I_SLOT) begin
          if (slot_ok) begin
            wr_eff = 1'b1;
            if (pend)
              state_nxt = ST_COPY;
          end else begin
            err_set = 1'b1;
          end
        end else if (prog_idx_r >= `CCS_I_SF2B2) begin
          // Rate coefficients wait in the staged bank until the slot advance.
          wr_prog = 1'b1;
          pend_set = 1'b1;
        end else begin
          wr_eff = 1'b1;
        end
      end
      ST_COPY: begin
        wr_eff = 1'b1;
        if (idx_r == `CCS_I_LAST) begin
          pend_clr = 1'b1;
          state_nxt = ST_IDLE;
        end
      end
      default: state_nxt = ST_LOAD;
    endcase
  end

  always @(posedge mclk) begin
    if (!rst_b) begin
      state_r <= ST_LOAD;
      idx_r <= `CCS_I_SLOT;
      prog_idx_r <= `CCS_I_SLOT;
      data_ready <= 1'b0;
    end else begin
      state_r <= state_nxt;
      if (state_r == ST_LOAD && idx_r == `CCS_I_LAST)
        data_ready <= 1'b1;
      if (cmd_go)
        prog_idx_r <= cmd_idx;
      if (state_r == ST_PROG)
        idx_r <= `CCS_I_SF2B2;
      else if ((state_r == ST_LOAD || state_r == ST_COPY) && idx_r != `CCS_I_LAST)
        idx_r <= idx_r + `CCS_I_ONE;
    end
  end

  // ----------------------------------------------------------------------
  // System registers
  // ----------------------------------------------------------------------
  // Reads are held off until the load is done, so no reset is needed here.
  always @(posedge mclk) begin
    if (state_r == ST_LOAD) begin
      sys_r[idx_r] <= rd_eff_data;
    end else if (acc_wr && bus_idx != `CCS_I_BAD) begin
      for (b = 0; b < 4; b = b + 1) begin
        if (avs_byteenable[b])
          sys_r[bus_idx][8*b +: 8] <= avs_writedata[8*b +: 8];
      end
    end
  end

  always @(posedge mclk) begin
    if (!rst_b)
      nvm_slot_r <= 8'h00;
    else if (state_r == ST_LOAD && idx_r == `CCS_I_SLOT)
      nvm_slot_r <= rd_eff_data[`CCS_SLOT_HI:`CCS_SLOT_LO];
    else if (state_r == ST_PROG && prog_idx_r == `CCS_I_SLOT && slot_ok)
      nvm_slot_r <= slot_new;
  end

  // A new error in the clearing cycle stays set.
  always @(posedge mclk) begin
    if (!rst_b)
      err_r <= 1'b0;
    else if (err_set)
      err_r <= 1'b1;
    else if (acc_wr && avs_address == `CCS_W_STAT && avs_writedata[`CCS_ST_ERR])
      err_r <= 1'b0;
  end

  // ----------------------------------------------------------------------
  // Active rate coefficients
  // ----------------------------------------------------------------------
  // Taken only while loading, so new values act after the next reset.
  always @(posedge mclk) begin
    if (!rst_b) begin
      scale_coef_quadratic <= 16'h0000;
      bias_coef_quadratic <= 16'h0000;
      bias_coef_linear <= 30'h0000_0000;
      bias_coef_constant <= 30'h0000_0000;
      scale_coef_linear <= 30'h0000_0000;
      scale_coef_constant <= 30'h0000_0000;
      mid_temperature_point <= 20'h0_0000;
    end else if (state_r == ST_LOAD) begin
      case (idx_r)
        `CCS_I_SF2B2: begin
          scale_coef_quadratic <= rd_eff_data[`CCS_HALF_HI:`CCS_HALF_LO];
          bias_coef_quadratic <= rd_eff_data[`CCS_LOW_HI:0];
        end
        `CCS_I_B1: bias_coef_linear <= rd_eff_data[`CCS_C30_HI:0];
        `CCS_I_B0: bias_coef_constant <= rd_eff_data[`CCS_C30_HI:0];
        `CCS_I_SF1: scale_coef_linear <= rd_eff_data[`CCS_C30_HI:0];
        `CCS_I_SF0: scale_coef_constant <= rd_eff_data[`CCS_C30_HI:0];
        `CCS_I_MID_TEMPERATURE_POINT: mid_temperature_point <= rd_eff_data[`CCS_MID_TEMPERATURE_POINT_HI:0];
        default: mid_temperature_point <= mid_temperature_point;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  ccs_tcal u_tcal (
    .mclk(mclk),
    .rst_b(rst_b),
    .raw_temp(raw_temp),
    .gain(sys_r[`CCS_I_TCAL][`CCS_GAIN_HI:`CCS_GAIN_LO]),
    .offset(sys_r[`CCS_I_TCAL][`CCS_OFS_HI:`CCS_OFS_LO]),
    .cal_en(data_ready & sys_r[`CCS_I_TSEL][`CCS_TSEL_BIT]),
    .temp_r(temp_out)
  );

  always @(posedge mclk) begin
    if (!rst_b || !data_ready)
      rate_out <= 24'h00_0000;
    else if (sys_r[`CCS_I_SLOT][`CCS_BYP_BIT])
      rate_out <= raw_rate;
    else
      rate_out <= comp_rate;
  end

  // ----------------------------------------------------------------------
  // Bus answer
  // ----------------------------------------------------------------------
  always @* begin
    rd_mux = `CCS_DEF_ZERO;
    if (bus_idx != `CCS_I_BAD)
      rd_mux = sys_r[bus_idx];
    else if (avs_address == `CCS_W_STAT) begin
      rd_mux[`CCS_SLOT_HI:`CCS_SLOT_LO] = nvm_slot_r;
      rd_mux[`CCS_ST_BUSY] = ~state_r[1];
      rd_mux[`CCS_ST_READY] = data_ready;
      rd_mux[`CCS_ST_PEND] = pend;
      rd_mux[`CCS_ST_ERR] = err_r;
    end else if (avs_address == `CCS_W_TOUT)
      rd_mux[15:0] = temp_out;
    else if (avs_address == `CCS_W_ROUT)
      rd_mux[23:0] = rate_out;
  end

  // One wait cycle per request; none is answered outside the idle state.
  always @(posedge mclk) begin
    if (!rst_b) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= `CCS_DEF_ZERO;
    end else if (avs_waitrequest && req && state_r == ST_IDLE) begin
      avs_waitrequest <= 1'b0;
      // Writes leave the last read answer standing on the data lines.
      if (avs_read)
        avs_readdata <= rd_mux;
    end else begin
      avs_waitrequest <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// ==== rtl/ccs_map.vh ====
// Address map, field layout and reset values of the calibration coefficient store.
`ifndef CCS_MAP_VH
`define CCS_MAP_VH

// ----------------------------------------------------------------------
// Word indices on the register bus
// ----------------------------------------------------------------------
`define CCS_W_SLOT 8'h02
`define CCS_W_TCAL 8'h04
`define CCS_W_TSEL 8'h09
`define CCS_W_SF2B2 8'h2e
`define CCS_W_B1 8'h2f
`define CCS_W_B0 8'h30
`define CCS_W_SF1 8'h31
`define CCS_W_SF0 8'h32
`define CCS_W_MID_TEMPERATURE_POINT 8'h33
`define CCS_W_CMD 8'h40
`define CCS_W_STAT 8'h41
`define CCS_W_TOUT 8'h42
`define CCS_W_ROUT 8'h43

// ----------------------------------------------------------------------
// Compact storage indices
// ----------------------------------------------------------------------
`define CCS_I_SLOT 4'h0
`define CCS_I_TCAL 4'h1
`define CCS_I_TSEL 4'h2
`define CCS_I_SF2B2 4'h3
`define CCS_I_B1 4'h4
`define CCS_I_B0 4'h5
`define CCS_I_SF1 4'h6
`define CCS_I_SF0 4'h7
`define CCS_I_MID_TEMPERATURE_POINT 4'h8
`define CCS_I_LAST 4'h8
`define CCS_I_BAD 4'hf
`define CCS_I_ONE 4'h1

// ----------------------------------------------------------------------
// Fields
// ----------------------------------------------------------------------
`define CCS_SLOT_HI 15
`define CCS_SLOT_LO 8
`define CCS_BYP_BIT 27
`define CCS_GAIN_HI 13
`define CCS_GAIN_LO 2
`define CCS_OFS_HI 27
`define CCS_OFS_LO 16
`define CCS_TSEL_BIT 2
`define CCS_GAIN_FRAC 9
`define CCS_HALF_HI 31
`define CCS_HALF_LO 16
`define CCS_LOW_HI 15
`define CCS_C30_HI 29
`define CCS_MID_TEMPERATURE_POINT_HI 19
`define CCS_CMD_HI 7
`define CCS_ST_BUSY 0
`define CCS_ST_READY 1
`define CCS_ST_PEND 2
`define CCS_ST_ERR 3

// ----------------------------------------------------------------------
// Reset and factory values
// ----------------------------------------------------------------------
`define CCS_DEF_SLOT 32'h0000_0100
`define CCS_DEF_TCAL 32'h0000_2000
`define CCS_DEF_ZERO 32'h0000_0000
`define CCS_SLOT_FULL 8'hff
`define CCS_T_MAX 16'hffff

`endif

// ==== rtl/ccs_nvm.v ====
// Nonvolatile word store with staged and effective banks.
`timescale 1ns/100ps
`default_nettype none
`include "ccs_map.vh"
module ccs_nvm (
  // Clock and factory erase
  input wire mclk,
  input wire nvm_clear_b,
  // Programming port
  input wire wr_prog,
  input wire wr_eff,
  input wire [3:0] wr_idx,
  input wire [31:0] wr_data,
  input wire pend_set,
  input wire pend_clr,
  // Read port
  input wire [3:0] rd_idx,
  output wire [31:0] rd_prog_data,
  output wire [31:0] rd_eff_data,
  output reg pend_r
);
  reg [31:0] prog_mem [0:8];
  reg [31:0] eff_mem [0:8];
  reg [8:0] prog_ok_r;
  reg [8:0] eff_ok_r;

  // ----------------------------------------------------------------------
  // Factory contents
  // ----------------------------------------------------------------------
  // Unwritten words read as factory values, so the arrays need no reset.
  function [31:0] dflt;
    input [3:0] i;
    begin
      case (i)
        `CCS_I_SLOT: dflt = `CCS_DEF_SLOT;
        `CCS_I_TCAL: dflt = `CCS_DEF_TCAL;
        default: dflt = `CCS_DEF_ZERO;
      endcase
    end
  endfunction

  always @(posedge mclk) begin
    if (wr_prog)
      prog_mem[wr_idx] <= wr_data;
    if (wr_eff)
      eff_mem[wr_idx] <= wr_data;
  end

  // The device reset leaves these alone; only a factory erase clears the valid bits, and pend_r also clears at the end of a copy.
  always @(posedge mclk) begin
    if (!nvm_clear_b) begin
      prog_ok_r <= 9'h000;
      eff_ok_r <= 9'h000;
      pend_r <= 1'b0;
    end else begin
      if (wr_prog)
        prog_ok_r[wr_idx] <= 1'b1;
      if (wr_eff)
        eff_ok_r[wr_idx] <= 1'b1;
      if (pend_set)
        pend_r <= 1'b1;
      else if (pend_clr)
        pend_r <= 1'b0;
    end
  end

  assign rd_prog_data = prog_ok_r[rd_idx] ? prog_mem[rd_idx] : dflt(rd_idx);
  assign rd_eff_data = eff_ok_r[rd_idx] ? eff_mem[rd_idx] : dflt(rd_idx);
endmodule
`default_nettype wire

// ==== rtl/ccs_tcal.v ====
// First-order temperature calibration with raw pass-through.
`timescale 1ns/100ps
`default_nettype none
`include "ccs_map.vh"
module ccs_tcal (
  // Clock and reset
  input wire mclk,
  input wire rst_b,
  // Raw sample and coefficients
  input wire [15:0] raw_temp,
  input wire [11:0] gain,
  input wire [11:0] offset,
  input wire cal_en,
  // Result
  output reg [15:0] temp_r
);
  wire [27:0] prod;
  wire [19:0] scaled;

  assign prod = gain * raw_temp;
  // Nine fraction bits drop here, leaving 20 LSB per degree.
  assign scaled = {1'b0, prod[27:`CCS_GAIN_FRAC]} + {8'h00, offset};

  // Saturation keeps a large offset from wrapping to a cold reading.
  always @(posedge mclk) begin
    if (!rst_b)
      temp_r <= 16'h0000;
    else if (!cal_en)
      temp_r <= raw_temp;
    else if (scaled[19:16] != 4'h0)
      temp_r <= `CCS_T_MAX;
    else
      temp_r <= scaled[15:0];
  end
endmodule
`default_nettype wire

// ==== verif/ccs_props.sv ====
// Concurrent checks on the ports of the coefficient store.
`timescale 1ns/100ps
`default_nettype none
module ccs_props (
  // Clock and reset
  input wire mclk,
  input wire rst_b,
  // Bus
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_readdata,
  input wire avs_waitrequest,
  // Data
  input wire [23:0] raw_rate,
  input wire [23:0] comp_rate,
  input wire [15:0] temp_out,
  input wire [23:0] rate_out,
  input wire data_ready,
  input wire [15:0] scale_coef_quadratic,
  input wire [29:0] bias_coef_linear
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  wire req = avs_read | avs_write;
  // The clear check must see the reset itself, so it keeps no disable.
  reset_state_a: assert property (disable iff (1'b0) !rst_b |=> avs_waitrequest &&
    !data_ready && temp_out == 16'h0000 && rate_out == 24'h000000) else $error("reset clear");
  load_time_a: assert property ($rose(rst_b) |-> !data_ready [*8] ##[1:2] data_ready)
    else $error("load length");
  load_busy_a: assert property (!data_ready |-> avs_waitrequest)
    else $error("answer during load");
  wait_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("wait low too long");
  ans_cause_a: assert property (!avs_waitrequest |-> $past(req))
    else $error("answer without request");
  ans_bound_a: assert property (req && avs_waitrequest && data_ready |->
    ##[1:12] !avs_waitrequest) else $error("answer late");
  rd_stand_a: assert property ($changed(avs_readdata) |-> avs_read && !avs_waitrequest)
    else $error("read data moved");
  coef_hold_a: assert property (data_ready && $past(data_ready) |->
    $stable(scale_coef_quadratic) && $stable(bias_coef_linear)) else $error("coef moved");
  rate_pick_a: assert property (data_ready && $past(data_ready) |->
    rate_out == $past(raw_rate) || rate_out == $past(comp_rate)) else $error("rate source");
  cover property (avs_write && !avs_waitrequest);
  cover property (avs_read && !avs_waitrequest);
  cover property ($rose(data_ready));
endmodule
bind ccs_top ccs_props i_ccs_props (.mclk(mclk), .rst_b(rst_b), .avs_read(avs_read),
  .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .raw_rate(raw_rate), .comp_rate(comp_rate), .temp_out(temp_out), .rate_out(rate_out),
  .data_ready(data_ready), .scale_coef_quadratic(scale_coef_quadratic),
  .bias_coef_linear(bias_coef_linear));
`default_nettype wire

// ==== verif/ccs_host.sv ====
// Host model: bus master and programming procedures.
`timescale 1ns/100ps
`default_nettype none
module ccs_host (
  // Clock
  input wire logic mclk,
  // Avalon-MM master
  output logic [7:0] avs_address,
  output logic avs_read,
  output logic avs_write,
  output logic [31:0] avs_writedata,
  output logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest
);
  initial begin
    avs_address = 8'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0000_0000;
    avs_byteenable = 4'hf;
  end
  // ------
  // Transfers
  // ------
  task automatic xfer(input logic [7:0] a, input logic wr, input logic [31:0] d,
    output logic [31:0] q);
    @(posedge mclk);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !wr;
    avs_write <= wr;
    @(posedge mclk);
    while (avs_waitrequest !== 1'b0) @(posedge mclk);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    // Stale data is not left on the lines once released.
    avs_writedata <= ~d;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(a, 1'b1, d, q);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    xfer(a, 1'b0, 32'h0000_0000, q);
  endtask
  task automatic set_field(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v);
    logic [31:0] q;
    rd(a, q);
    wr(a, (q & ~m) | (v & m));
  endtask
  task automatic program_rate(input logic [31:0] c [6]);
    logic [7:0] a [6] = '{8'h2e, 8'h31, 8'h32, 8'h2f, 8'h30, 8'h33};
    for (int i = 0; i < 6; i++) begin
      set_field(a[i], i == 0 ? 32'hffff_ffff : i == 5 ? 32'h000f_ffff : 32'h3fff_ffff, c[i]);
      wr(8'h40, {24'h000000, a[i]});
    end
  endtask
  task automatic advance_slot();
    logic [31:0] q;
    rd(8'h41, q);
    set_field(8'h02, 32'h0000_ff00, {16'h0000, q[14:8], 1'b1, 8'h00});
    wr(8'h40, 32'h0000_0002);
  endtask
  task automatic commit_temp();
    set_field(8'h09, 32'h0000_0004, 32'h0000_0004);
    wr(8'h40, 32'h0000_0004);
    wr(8'h40, 32'h0000_0009);
  endtask
endmodule
`default_nettype wire

// ==== verif/ccs_top_tb_top.sv ====
// Self-checking bench of the calibration coefficient store.
`timescale 1ns/100ps
`default_nettype none
module ccs_top_tb_top;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic nvm_clear_b = 1'b0;
  logic [15:0] raw_temp = 16'h0100;
  logic [23:0] raw_rate = 24'h12_3456;
  logic [23:0] comp_rate = 24'h65_4321;
  wire [7:0] avs_address;
  wire avs_read;
  wire avs_write;
  wire [31:0] avs_writedata;
  wire [3:0] avs_byteenable;
  wire [31:0] avs_readdata;
  wire avs_waitrequest;
  wire [15:0] temp_out;
  wire [23:0] rate_out;
  wire data_ready;
  wire [15:0] sq;
  wire [15:0] bq;
  wire [29:0] bl;
  wire [29:0] bc;
  wire [29:0] sl;
  wire [29:0] sc;
  wire [19:0] mid;
  int miscompares = 0;
  int n_compared = 0;
  int cycles = 0;
  logic [31:0] q;
  logic [31:0] e;
  logic [15:0] traw [3] = '{16'h0100, 16'h0200, 16'hf000};
  logic [31:0] coefs [6] = '{32'h1234_5678, 32'h0abc_def1, 32'hd357_9bdf, 32'h2468_ace0,
    32'h3fed_cba9, 32'h000a_5a5a};
  always #2 mclk = ~mclk;
  ccs_top i_ccs_top (.mclk(mclk), .rst_b(rst_b), .nvm_clear_b(nvm_clear_b),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .raw_temp(raw_temp),
    .raw_rate(raw_rate), .comp_rate(comp_rate), .temp_out(temp_out), .rate_out(rate_out),
    .data_ready(data_ready), .scale_coef_quadratic(sq), .bias_coef_quadratic(bq),
    .bias_coef_linear(bl), .bias_coef_constant(bc), .scale_coef_linear(sl),
    .scale_coef_constant(sc), .mid_temperature_point(mid));
  ccs_host i_ccs_host (.mclk(mclk), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
  // ------
  // Checking and closing
  // ------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // The whole run needs a few hundred cycles; this cuts a hang short.
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      wrap_up();
    end
  end
  task automatic do_reset();
    rst_b <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_b <= 1'b1;
    while (data_ready !== 1'b1) @(posedge mclk);
  endtask
  initial begin
    @(posedge mclk);
    nvm_clear_b <= 1'b1;
    do_reset();
    i_ccs_host.rd(8'h02, q);
    check(q, 32'h0000_0100);
    i_ccs_host.rd(8'h04, q);
    check(q, 32'h0000_2000);
    i_ccs_host.rd(8'h09, q);
    check(q, 32'h0000_0000);
    i_ccs_host.rd(8'h7f, q);
    check(q, 32'h0000_0000);
    check(rate_out, comp_rate);
    $display("test defaults done");
    i_ccs_host.set_field(8'h09, 32'h0000_0004, 32'h0000_0000);
    for (int i = 1; i < 3; i++) begin
      raw_temp <= {i[7:0], 8'h00};
      repeat (4) @(posedge mclk);
      i_ccs_host.rd(8'h42, q);
      check(q, {16'h0000, i[7:0], 8'h00});
    end
    i_ccs_host.set_field(8'h04, 32'h0fff_3ffc, 32'h0020_0c00);
    i_ccs_host.set_field(8'h09, 32'h0000_0004, 32'h0000_0004);
    foreach (traw[i]) begin
      raw_temp <= traw[i];
      repeat (4) @(posedge mclk);
      e = ((traw[i] * 32'h0000_0300) >> 9) + 32'h0000_0020;
      if (e > 32'h0000_ffff) e = 32'h0000_ffff;
      check(temp_out, e);
    end
    raw_temp <= 16'h0100;
    i_ccs_host.commit_temp();
    $display("test temperature done");
    i_ccs_host.set_field(8'h02, 32'h0800_0000, 32'h0800_0000);
    repeat (4) @(posedge mclk);
    check(rate_out, raw_rate);
    i_ccs_host.set_field(8'h02, 32'h0800_0000, 32'h0000_0000);
    $display("test bypass done");
    i_ccs_host.program_rate(coefs);
    i_ccs_host.rd(8'h41, q);
    check(q[2], 1'b1);
    do_reset();
    check(sq, 16'h0000);
    i_ccs_host.advance_slot();
    i_ccs_host.rd(8'h41, q);
    check(q[15:8], 8'h03);
    check(q[2], 1'b0);
    check(bl, 30'h0);
    do_reset();
    check(sq, coefs[0][31:16]);
    check(bq, coefs[0][15:0]);
    check(sl, coefs[1][29:0]);
    check(sc, coefs[2][29:0]);
    check(bl, coefs[3][29:0]);
    check(bc, coefs[4][29:0]);
    check(mid, coefs[5][19:0]);
    repeat (2) @(posedge mclk);
    check(temp_out, 16'h01a0);
    i_ccs_host.rd(8'h02, q);
    check(q[15:8], 8'h03);
    $display("test programming done");
    i_ccs_host.set_field(8'h02, 32'h0000_ff00, 32'h0000_0500);
    i_ccs_host.wr(8'h40, 32'h0000_0002);
    i_ccs_host.rd(8'h41, q);
    check(q[15:8], 8'h03);
    check(q[3], 1'b1);
    i_ccs_host.wr(8'h41, 32'h0000_0008);
    i_ccs_host.rd(8'h41, q);
    check(q[3], 1'b0);
    e = 32'h0000_0003;
    repeat (6) begin
      i_ccs_host.advance_slot();
      e = {e[30:0], 1'b1};
      i_ccs_host.rd(8'h41, q);
      check(q[15:8], e[7:0]);
    end
    i_ccs_host.wr(8'h40, 32'h0000_002e);
    i_ccs_host.rd(8'h41, q);
    check(q[3], 1'b1);
    $display("test slots done");
    wrap_up();
  end
endmodule
`default_nettype wire
